// ### rtl/dckpm_pkg.sv
package dckpm_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int unsigned NUM_RANKS  = 4;
   localparam int unsigned INIT_CNT_W = 13;
   localparam int unsigned EXIT_CNT_W = 5;

   typedef logic [NUM_RANKS-1:0] dckpm_rank_t;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_MHZ      = 25;
   localparam int unsigned CLK_NS       = 40;
   localparam int unsigned CKE_INIT_US  = 200;
   // One cycle beyond the minimum: the hold must be strictly longer
   localparam int unsigned CKE_INIT_CLKS = CKE_INIT_US * CLK_MHZ + 1;
   localparam int unsigned XP_NS        = 24;
   localparam int unsigned XP_CLKS      = (XP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned XPDLL_CLKS   = 20;
   localparam int unsigned SR_EXIT_NS   = 200;
   localparam int unsigned SR_EXIT_CLKS = (SR_EXIT_NS + CLK_NS - 1) / CLK_NS;

   // ------------------------------------------------------------
   // Power-down configuration
   // ------------------------------------------------------------
   localparam logic [3:0]  PD_NONE      = 4'h0;
   localparam logic [3:0]  PD_ACTIVE    = 4'h1;
   localparam logic [3:0]  PD_PRECHARGE = 4'h6;

   // Bits 15:12 type, bits 11:0 idle threshold in memory clocks
   typedef struct packed {
      logic [3:0]  powerdown_type_field;
      logic [11:0] rank_idle_threshold_field;
   } dckpm_pdcfg_t;

   typedef struct packed {
      dckpm_rank_t cke;
      dckpm_rank_t clk_en;
      dckpm_rank_t termination_enable_out;
      dckpm_rank_t cs_en;
   } dckpm_pins_t;

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_HOLD     = 8'h01,
      ST_INIT     = 8'h02,
      ST_ACTIVE   = 8'h04,
      ST_REF_UP   = 8'h08,
      ST_REFRESH  = 8'h10,
      ST_DRAIN    = 8'h20,
      ST_SELF_REF = 8'h40,
      ST_SR_EXIT  = 8'h80
   } dckpm_state_t;

   typedef enum logic [3:0] {
      RK_UP    = 4'h1,
      RK_CLOSE = 4'h2,
      RK_DOWN  = 4'h4,
      RK_EXIT  = 4'h8
   } dckpm_rank_st_t;

endpackage

// ### rtl/dckpm_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module dckpm_sync2 #(
   parameter int unsigned WIDTH = 4
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ### rtl/dckpm_rank_pd.sv
`timescale 1ns/1ns
`default_nettype none
module dckpm_rank_pd (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Control
   input  wire logic        en,
   input  wire logic [3:0]  pd_type,
   input  wire logic [11:0] threshold,
   input  wire logic        wake,
   input  wire logic        force_pd,
   // Traffic
   input  wire logic        req,
   input  wire logic        queued,
   input  wire logic        pages_open,
   // Result
   output logic             cke,
   output logic             ready,
   output logic             close_req
);
   import dckpm_pkg::*;

   dckpm_rank_st_t        st;
   dckpm_rank_st_t        next_st;
   logic [11:0]           idle_cnt;
   logic [EXIT_CNT_W-1:0] exit_cnt;
   logic                  ppd;
   logic                  pd_on;
   logic                  busy;

   assign ppd   = pd_type == PD_PRECHARGE;
   assign pd_on = ppd || (pd_type == PD_ACTIVE);
   assign busy  = req || queued;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_cnt <= '0;
      end else if (req || !en) begin
         idle_cnt <= '0;
      end else if (idle_cnt != 12'hFFF) begin
         idle_cnt <= idle_cnt + 12'h001;
      end
   end

   always_comb begin
      next_st = st;
      case (st)
         RK_UP: begin
            if (en && pd_on && !busy && !wake && (idle_cnt >= threshold || force_pd)) begin
               next_st = (ppd && pages_open) ? RK_CLOSE : RK_DOWN;
            end
         end
         RK_CLOSE: begin
            if (busy || wake || !en) next_st = RK_UP;
            else if (!pages_open) next_st = RK_DOWN;
         end
         RK_DOWN: begin
            if (req || wake || !en) next_st = RK_EXIT;
         end
         RK_EXIT: begin
            if (exit_cnt == '0) next_st = RK_UP;
         end
         default: next_st = RK_UP;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st        <= RK_UP;
         exit_cnt  <= '0;
         cke       <= 1'b0;
         ready     <= 1'b0;
         close_req <= 1'b0;
      end else begin
         st        <= next_st;
         cke       <= next_st != RK_DOWN;
         ready     <= next_st == RK_UP;
         close_req <= next_st == RK_CLOSE;
         // DLL-off exit needs the longer delay before data moves
         if (st == RK_DOWN && next_st == RK_EXIT) begin
            exit_cnt <= ppd ? EXIT_CNT_W'(XPDLL_CLKS - 1) : EXIT_CNT_W'(XP_CLKS - 1);
         end else if (exit_cnt != '0) begin
            exit_cnt <= exit_cnt - 1'b1;
         end
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   property p_idle_restart;
      req |=> idle_cnt == '0;
   endproperty
   a_idle_restart: assert property (p_idle_restart) else $error("idle count not restarted");

   property p_ppd_closed;
      $fell(cke) && ppd |-> !$past(pages_open);
   endproperty
   a_ppd_closed: assert property (p_ppd_closed) else $error("precharge down with open pages");

   property p_exit_hold;
      st == RK_DOWN && req |=> cke && !ready;
   endproperty
   a_exit_hold: assert property (p_exit_hold) else $error("rank ready before exit delay");
endmodule
`default_nettype wire

// ### rtl/dckpm_top.sv
`timescale 1ns/1ns
`default_nettype none
module dckpm_top #(
   parameter int unsigned CKE_INIT_CYCLES = dckpm_pkg::CKE_INIT_CLKS
) (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   // Configuration
   input  wire logic                   cke_enable_write,
   input  wire dckpm_pkg::dckpm_pdcfg_t pd_cfg,
   input  wire dckpm_pkg::dckpm_rank_t rank_populated,
   input  wire logic                   channel_used,
   input  wire dckpm_pkg::dckpm_rank_t graphics_rank,
   // Traffic
   input  wire dckpm_pkg::dckpm_rank_t rank_req,
   input  wire dckpm_pkg::dckpm_rank_t rank_queued,
   input  wire dckpm_pkg::dckpm_rank_t pages_open,
   input  wire logic                   mem_idle,
   input  wire logic                   cycles_drained,
   input  wire logic                   refresh_req,
   input  wire logic                   refresh_done,
   // Package power state
   input  wire logic                   pkg_c3_deep,
   input  wire logic                   suspend_req,
   // Memory pins
   input  wire dckpm_pkg::dckpm_rank_t rx_pin,
   output dckpm_pkg::dckpm_pins_t      pins,
   output dckpm_pkg::dckpm_rank_t      tx_oe_n,
   output dckpm_pkg::dckpm_rank_t      rx_en,
   output dckpm_pkg::dckpm_rank_t      rx_data,
   output logic                        dll_en,
   output logic                        memory_reset_pin,
   output logic                        vref_en,
   // Status
   output dckpm_pkg::dckpm_rank_t      rank_ready,
   output dckpm_pkg::dckpm_rank_t      precharge_all_req,
   output logic                        refresh_go,
   output logic                        self_refresh,
   output logic                        io_power_gating,
   output logic                        train_skip,
   output logic                        train_restore
);
   import dckpm_pkg::*;

   dckpm_state_t          state;
   dckpm_state_t          next_state;
   logic [INIT_CNT_W-1:0] init_cnt;
   logic [EXIT_CNT_W-1:0] sr_cnt;
   dckpm_rank_t           used;
   dckpm_rank_t           sr_ranks;
   dckpm_rank_t           rk_en;
   dckpm_rank_t           rk_cke;
   dckpm_rank_t           rk_ready;
   dckpm_rank_t           rk_close;
   dckpm_rank_t           rx_sync;
   dckpm_rank_t           next_cke;
   logic                  dyn_pd;
   logic                  want_sr;
   logic                  leave_sr;
   logic                  ranks_up;
   logic                  ref_phase;
   logic                  force_pd;

   // ------------------------------------------------------------
   // Conditions
   // ------------------------------------------------------------
   // A rank of an unused channel counts as unused
   assign used      = rank_populated & {NUM_RANKS{channel_used}};
   assign dyn_pd    = (pd_cfg.powerdown_type_field == PD_ACTIVE) ||
                      (pd_cfg.powerdown_type_field == PD_PRECHARGE);
   assign want_sr   = suspend_req || (pkg_c3_deep && mem_idle);
   assign leave_sr  = !want_sr || (|(rank_req & sr_ranks));
   assign ranks_up  = &(rk_ready | ~used);
   assign ref_phase = (state == ST_REF_UP) || (state == ST_REFRESH);
   assign rk_en     = used & {NUM_RANKS{(state == ST_ACTIVE) || ref_phase}};

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_HOLD: begin
            if (cke_enable_write) next_state = ST_INIT;
         end
         ST_INIT: begin
            if (init_cnt == INIT_CNT_W'(CKE_INIT_CYCLES - 1)) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (want_sr) begin
               next_state = ST_DRAIN;
            end else if (refresh_req) begin
               next_state = dyn_pd ? ST_REF_UP : ST_REFRESH;
            end
         end
         ST_REF_UP: begin
            if (ranks_up) next_state = ST_REFRESH;
         end
         ST_REFRESH: begin
            if (refresh_done) next_state = ST_ACTIVE;
         end
         ST_DRAIN: begin
            if (cycles_drained) next_state = ST_SELF_REF;
         end
         ST_SELF_REF: begin
            if (leave_sr) next_state = ST_SR_EXIT;
         end
         ST_SR_EXIT: begin
            if (sr_cnt == '0) next_state = ST_ACTIVE;
         end
         default: next_state = ST_HOLD;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // Power-up hold counter; runs only after the software release
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         init_cnt <= '0;
      end else if (state == ST_INIT) begin
         init_cnt <= init_cnt + 1'b1;
      end else begin
         init_cnt <= '0;
      end
   end

   // Self-refresh exit delay before commands resume
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sr_cnt <= '0;
      end else if (state == ST_SELF_REF && leave_sr) begin
         sr_cnt <= EXIT_CNT_W'(SR_EXIT_CLKS - 1);
      end else if (sr_cnt != '0) begin
         sr_cnt <= sr_cnt - 1'b1;
      end
   end

   // Graphics ranks stay out of self-refresh so display fetch survives
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sr_ranks <= '0;
      end else if (state == ST_DRAIN && cycles_drained) begin
         sr_ranks <= used & ~graphics_rank;
      end else if (next_state == ST_ACTIVE) begin
         sr_ranks <= '0;
      end
   end

   // Refresh end pushes every rank with no request or queued work straight back down
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         force_pd <= 1'b0;
      end else begin
         force_pd <= state == ST_REFRESH && refresh_done && dyn_pd;
      end
   end

   // ------------------------------------------------------------
   // Per-rank power-down
   // ------------------------------------------------------------
   for (genvar i = 0; i < NUM_RANKS; i++) begin : g_rank
      dckpm_rank_pd u_rank (
         .core_clk   (core_clk),
         .arst_n     (arst_n),
         .en         (rk_en[i]),
         .pd_type    (pd_cfg.powerdown_type_field),
         .threshold  (pd_cfg.rank_idle_threshold_field),
         .wake       (ref_phase),
         .force_pd   (force_pd),
         .req        (rank_req[i]),
         .queued     (rank_queued[i]),
         .pages_open (pages_open[i]),
         .cke        (rk_cke[i]),
         .ready      (rk_ready[i]),
         .close_req  (rk_close[i])
      );
   end

   dckpm_sync2 #(
      .WIDTH (NUM_RANKS)
   ) u_rx_sync (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .d        (rx_pin),
      .q        (rx_sync)
   );

   // ------------------------------------------------------------
   // Clock enables
   // ------------------------------------------------------------
   always_comb begin
      case (state)
         ST_HOLD,
         ST_INIT:     next_cke = '0;
         ST_DRAIN:    next_cke = used & rk_cke & (cycles_drained ? graphics_rank : '1);
         ST_SELF_REF: next_cke = used & rk_cke & ~sr_ranks;
         ST_SR_EXIT:  next_cke = used;
         default:     next_cke = used & rk_cke;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pins <= '0;
      end else begin
         pins.cke                    <= next_cke;
         pins.clk_en                 <= used;
         pins.termination_enable_out <= used;
         pins.cs_en                  <= used;
      end
   end

   // ------------------------------------------------------------
   // Pin buffers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_oe_n <= '1;
         rx_en   <= '0;
         dll_en  <= 1'b0;
      end else begin
         tx_oe_n <= ~used;
         rx_en   <= used;
         dll_en  <= |used;
      end
   end

   // Noise on an idle pin must never look like data
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_data <= '0;
      end else begin
         rx_data <= rx_sync & used;
      end
   end

   // ------------------------------------------------------------
   // Power state and training
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         memory_reset_pin <= 1'b0;
         vref_en          <= 1'b0;
         io_power_gating  <= 1'b0;
         self_refresh     <= 1'b0;
      end else begin
         // These stay valid through gating; only bulk I/O loses power
         memory_reset_pin <= next_state != ST_HOLD;
         vref_en          <= 1'b1;
         io_power_gating  <= next_state == ST_SELF_REF && pkg_c3_deep;
         self_refresh     <= next_state == ST_SELF_REF;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         train_skip    <= 1'b0;
         train_restore <= 1'b0;
      end else begin
         train_skip    <= next_state == ST_SR_EXIT;
         train_restore <= state == ST_SR_EXIT && sr_cnt == '0;
      end
   end

   // ------------------------------------------------------------
   // Command gating
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rank_ready        <= '0;
         precharge_all_req <= '0;
         refresh_go        <= 1'b0;
      end else begin
         rank_ready        <= rk_ready & used & {NUM_RANKS{next_state == ST_ACTIVE}};
         precharge_all_req <= rk_close & used;
         refresh_go        <= (state == ST_ACTIVE && !want_sr && refresh_req && !dyn_pd) ||
                              (state == ST_REF_UP && ranks_up);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence s_release;
      state == ST_HOLD && cke_enable_write;
   endsequence

   sequence s_sr_leave;
      state == ST_SELF_REF && leave_sr;
   endsequence

   property p_hold_low;
      state == ST_HOLD |=> pins.cke == '0;
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("CKE high before release");

   property p_init_wait;
      s_release |=> (pins.cke == '0) [*8];
   endproperty
   a_init_wait: assert property (p_init_wait) else $error("CKE rose too soon");

   property p_init_len;
      state == ST_ACTIVE && $past(state) == ST_INIT |->
         $past(init_cnt) == INIT_CNT_W'(CKE_INIT_CYCLES - 1);
   endproperty
   a_init_len: assert property (p_init_len) else $error("init hold length wrong");

   property p_sr_cke;
      state == ST_SELF_REF |=> (pins.cke & $past(sr_ranks)) == '0;
   endproperty
   a_sr_cke: assert property (p_sr_cke) else $error("CKE high in self-refresh");

   property p_drain_first;
      $rose(state == ST_SELF_REF) |-> $past(cycles_drained);
   endproperty
   a_drain_first: assert property (p_drain_first) else $error("self-refresh before drain");

   property p_ref_all_up;
      refresh_go && dyn_pd |-> pins.cke == $past(used, 2);
   endproperty
   a_ref_all_up: assert property (p_ref_all_up) else $error("refresh with rank down");

   property p_unused_off;
      ##1 ((pins.clk_en | pins.cs_en | ~tx_oe_n | rx_data) & ~$past(used)) == '0;
   endproperty
   a_unused_off: assert property (p_unused_off) else $error("unused rank driven");

   property p_gating_pins;
      io_power_gating |-> memory_reset_pin && vref_en && self_refresh;
   endproperty
   a_gating_pins: assert property (p_gating_pins) else $error("critical pin lost in gating");

   property p_restore;
      s_sr_leave |=> train_skip ##[1:40] train_restore;
   endproperty
   a_restore: assert property (p_restore) else $error("training not restored");
endmodule
`default_nettype wire

// ### verification/dckpm_rank_model.sv
`timescale 1ns/1ns
`default_nettype none
module dckpm_rank_model
   import dckpm_pkg::*;
(
   // Clock
   input  wire logic        core_clk,
   // Controller side
   input  wire dckpm_rank_t cke,
   input  wire dckpm_rank_t rank_req,
   input  wire dckpm_rank_t precharge_all_req,
   // Rank state
   output var dckpm_rank_t  pages_open
);
   // ------------------------------------------------------------
   // Open rows
   // ------------------------------------------------------------
   // A request opens a row; a close is only taken while CKE is high
   initial pages_open = 4'h0;
   always @(posedge core_clk) begin
      pages_open <= (pages_open | rank_req) & ~(precharge_all_req & cke);
   end
endmodule
`default_nettype wire

// ### verification/dckpm_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module dckpm_tb_top;
   import dckpm_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int INIT = 16;
   logic         core_clk, arst_n, cke_enable_write, channel_used, mem_idle, cycles_drained;
   logic         refresh_req, refresh_done, pkg_c3_deep, suspend_req, refresh_go, self_refresh;
   logic         dll_en, memory_reset_pin, vref_en, io_power_gating, train_skip, train_restore;
   dckpm_pdcfg_t pd_cfg;
   dckpm_rank_t  rank_populated, graphics_rank, rank_req, rank_queued, pages_open, rx_pin;
   dckpm_rank_t  tx_oe_n, rx_en, rx_data, rank_ready, precharge_all_req;
   dckpm_pins_t  pins;
   int           fails, samples_checked;

   always #20 core_clk = ~core_clk;

   dckpm_top #(.CKE_INIT_CYCLES(INIT)) uut (.core_clk(core_clk), .arst_n(arst_n),
      .cke_enable_write(cke_enable_write), .pd_cfg(pd_cfg), .rank_populated(rank_populated),
      .channel_used(channel_used), .graphics_rank(graphics_rank), .rank_req(rank_req),
      .rank_queued(rank_queued), .pages_open(pages_open), .mem_idle(mem_idle),
      .cycles_drained(cycles_drained), .refresh_req(refresh_req), .refresh_done(refresh_done),
      .pkg_c3_deep(pkg_c3_deep), .suspend_req(suspend_req), .rx_pin(rx_pin), .pins(pins),
      .tx_oe_n(tx_oe_n), .rx_en(rx_en), .rx_data(rx_data), .dll_en(dll_en),
      .memory_reset_pin(memory_reset_pin), .vref_en(vref_en), .rank_ready(rank_ready),
      .precharge_all_req(precharge_all_req), .refresh_go(refresh_go),
      .self_refresh(self_refresh), .io_power_gating(io_power_gating),
      .train_skip(train_skip), .train_restore(train_restore));

   dckpm_rank_model ranks (.core_clk(core_clk), .cke(pins.cke), .rank_req(rank_req),
      .precharge_all_req(precharge_all_req), .pages_open(pages_open));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic report_and_stop;
      if (fails == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_init;
      cyc(4);
      `CHK("cke_hold", 4'h0, pins.cke)
      `CHK("oe_unused", 4'h8, tx_oe_n)
      `CHK("vref", 1'b1, vref_en)
      cke_enable_write = 1'b1;
      cyc(1);
      cke_enable_write = 1'b0;
      cyc(INIT);
      `CHK("cke_init", 4'h0, pins.cke)
      cyc(4);
      `CHK("cke_up", 4'h7, pins.cke)
   endtask

   task automatic t_apd;
      pd_cfg = {PD_ACTIVE, 12'h002};
      rank_queued = 4'h2;
      cyc(8);
      `CHK("apd_per_rank", 4'h2, pins.cke)
      rank_queued = 4'h0;
      rank_req = 4'h1;
      cyc(1);
      rank_req = 4'h0;
      cyc(1);
      `CHK("wake_cke", 2'b10, {pins.cke[0], rank_ready[0]})
      cyc(1);
      `CHK("wake_ready", 1'b1, rank_ready[0])
      cyc(4);
      `CHK("apd_open", 2'b01, {pins.cke[0], pages_open[0]})
   endtask

   task automatic t_ppd;
      pd_cfg = {PD_PRECHARGE, 12'h002};
      rank_req = 4'h1;
      cyc(1);
      rank_req = 4'h0;
      for (int i = 0; i < 60 && precharge_all_req[0] !== 1'b1; i++) cyc(1);
      `CHK("close_first", 3'b111, {precharge_all_req[0], pins.cke[0], pages_open[0]})
      for (int i = 0; i < 20 && pins.cke[0] !== 1'b0; i++) cyc(1);
      `CHK("ppd_closed", 2'b00, {pins.cke[0], pages_open[0]})
   endtask

   task automatic t_refresh;
      refresh_req = 1'b1;
      for (int i = 0; i < 80 && refresh_go !== 1'b1; i++) cyc(1);
      `CHK("ref_all_up", 5'h17, {refresh_go, pins.cke})
      refresh_req = 1'b0;
      cyc(2);
      refresh_done = 1'b1;
      cyc(1);
      refresh_done = 1'b0;
      for (int i = 0; i < 40 && pins.cke !== 4'h0; i++) cyc(1);
      `CHK("ref_all_down", 4'h0, pins.cke)
   endtask

   task automatic t_sr;
      graphics_rank = 4'h2;
      pkg_c3_deep = 1'b1;
      mem_idle = 1'b1;
      cyc(3);
      `CHK("sr_drain", 1'b0, self_refresh)
      cycles_drained = 1'b1;
      for (int i = 0; i < 10 && self_refresh !== 1'b1; i++) cyc(1);
      `CHK("sr_cke", 4'h0, pins.cke & 4'h5)
      `CHK("sr_pins", 2'b11, {io_power_gating, memory_reset_pin})
      cyc(6);
      `CHK("sr_hold", 5'h10, {self_refresh, pins.cke & 4'h5})
      pkg_c3_deep = 1'b0;
      for (int i = 0; i < 10 && train_skip !== 1'b1; i++) cyc(1);
      `CHK("sr_skip", 1'b1, train_skip)
      for (int i = 0; i < 10 && train_restore !== 1'b1; i++) cyc(1);
      `CHK("sr_restore", 1'b1, train_restore)
   endtask

   task automatic t_unused;
      rx_pin = 4'hF;
      cyc(4);
      `CHK("rx_gate", 8'h77, {rx_en, rx_data})
      `CHK("pins_used", 12'h777, {pins.clk_en, pins.termination_enable_out, pins.cs_en})
      channel_used = 1'b0;
      cyc(4);
      `CHK("chan_off", 16'h0000, pins)
      `CHK("io_off", 13'h1E00, {tx_oe_n, rx_en, rx_data, dll_en})
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      {core_clk, arst_n, cke_enable_write, mem_idle, cycles_drained} = '0;
      {refresh_req, refresh_done, pkg_c3_deep, suspend_req} = '0;
      {pd_cfg, graphics_rank, rank_req, rank_queued, rx_pin} = '0;
      {fails, samples_checked} = '0;
      channel_used = 1'b1;
      rank_populated = 4'h7;
      cyc(16);
      arst_n = 1'b1;
      t_init();
      t_apd();
      t_ppd();
      t_refresh();
      t_sr();
      t_unused();
      report_and_stop();
   end

   // Whole run is under two hundred clocks
   initial begin
      #160000;
      fails++;
      report_and_stop();
   end
endmodule
`default_nettype wire
